// [core/crd_map.vh]
`ifndef CRD_MAP_VH
`define CRD_MAP_VH

// Bus cycle is three clocks: setup, bank half, data half
`define CRD_PH_SETUP 2'h0
`define CRD_PH_BANK 2'h1
`define CRD_PH_DATA 2'h2

// Opcode encodings understood by the sequencer
`define CRD_OP_BRK 8'h00
`define CRD_OP_AND_IMM 8'h29
`define CRD_OP_ADC_IMM 8'h69
`define CRD_OP_STA_DIR 8'h85
`define CRD_OP_LDX_IMM 8'hA2
`define CRD_OP_LDA_XIND 8'hA1
`define CRD_OP_LDA_DIR 8'hA5
`define CRD_OP_LDA_IMM 8'hA9
`define CRD_OP_LDA_INDY 8'hB1
`define CRD_OP_LDA_ABX 8'hBD
`define CRD_OP_REP 8'hC2
`define CRD_OP_BNE 8'hD0
`define CRD_OP_SEP 8'hE2
`define CRD_OP_NOP 8'hEA
`define CRD_OP_XBA 8'hEB
`define CRD_OP_XCE 8'hFB

// Status bit positions
`define CRD_P_C 0
`define CRD_P_Z 1
`define CRD_P_I 2
`define CRD_P_D 3
`define CRD_P_X 4
`define CRD_P_B 4
`define CRD_P_M 5
`define CRD_P_V 6
`define CRD_P_N 7

// Reset values
`define CRD_RST_P 8'h34
`define CRD_RST_SP 16'h01FF
`define CRD_RST_BANK 8'h00
`define CRD_RST_DIR 16'h0000
`define CRD_SP_PAGE 8'h01

// Vector addresses (low byte; high byte at +1)
`define CRD_VEC_IRQ_EMU 16'hFFFE
`define CRD_VEC_IRQ_NAT 16'hFFEE
`define CRD_VEC_BRK_EMU 16'hFFFE
`define CRD_VEC_BRK_NAT 16'hFFE6

// ALU operations
`define CRD_ALU_ADD 2'h0
`define CRD_ALU_AND 2'h1
`define CRD_ALU_PASS 2'h2

// Register port offsets
`define CRD_REG_CTRL 5'h00
`define CRD_REG_A_LO 5'h01
`define CRD_REG_A_HI 5'h02
`define CRD_REG_X_LO 5'h03
`define CRD_REG_X_HI 5'h04
`define CRD_REG_Y_LO 5'h05
`define CRD_REG_Y_HI 5'h06
`define CRD_REG_P 5'h07
`define CRD_REG_EMU 5'h08
`define CRD_REG_DBANK 5'h09
`define CRD_REG_PBANK 5'h0A
`define CRD_REG_PC_LO 5'h0B
`define CRD_REG_PC_HI 5'h0C
`define CRD_REG_DIR_LO 5'h0D
`define CRD_REG_DIR_HI 5'h0E
`define CRD_REG_STEP 5'h0F
`define CRD_REG_SP_LO 5'h10
`define CRD_REG_SP_HI 5'h11
`define CRD_REG_OPCODE 5'h12
`define CRD_CTRL_RST 8'h01

`endif

// [core/crd_alu.v]
`timescale 1ns/10ps
`include "crd_map.vh"

module crd_alu (
	input wire [15:0] a,
	input wire [15:0] b,
	input wire ci,
	input wire [1:0] op,
	input wire wide,
	output reg [15:0] y,
	output reg co,
	output reg vo,
	output reg no,
	output reg zo
);

reg [16:0] sum;
reg [8:0] sum8;

always @* begin
	sum = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
	sum8 = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, ci};
	y = 16'h0000;
	co = 1'b0;
	vo = 1'b0;
	case (op)
	`CRD_ALU_ADD: begin
		if (wide) begin
			y = sum[15:0];
			co = sum[16];
			vo = (a[15] == b[15]) && (sum[15] != a[15]);
		end else begin
			// Narrow mode leaves the upper byte of operand a untouched
			y = {a[15:8], sum8[7:0]};
			co = sum8[8];
			vo = (a[7] == b[7]) && (sum8[7] != a[7]);
		end
	end
	`CRD_ALU_AND: begin
		y = wide ? (a & b) : {a[15:8], a[7:0] & b[7:0]};
	end
	default: begin
		y = wide ? b : {a[15:8], b[7:0]};
	end
	endcase
	no = wide ? y[15] : y[7];
	zo = wide ? (y == 16'h0000) : (y[7:0] == 8'h00);
end

endmodule

// [core/crd_datapath.v]
`timescale 1ns/10ps
`include "crd_map.vh"

module crd_datapath #(
	parameter [15:0] RESET_PC = 16'h0000
) (
	input wire clk,
	input wire rst,
	input wire [7:0] d_in,
	output reg [7:0] d_out,
	output reg d_oe_n,
	output reg [15:0] addr,
	output reg rw,
	output reg data_address_valid,
	output reg program_address_valid,
	output reg vector_pull_n,
	output wire emulation,
	input wire irq_n,
	input wire [4:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [7:0] reg_rdata
);

localparam [2:0] K_INT = 3'd0;
localparam [2:0] K_FET = 3'd1;
localparam [2:0] K_PRG = 3'd2;
localparam [2:0] K_DRD = 3'd3;
localparam [2:0] K_DWR = 3'd4;
localparam [2:0] K_PUSH = 3'd5;
localparam [2:0] K_VEC = 3'd6;

reg [1:0] ph_r;
reg [3:0] cycle_step_counter;
reg [7:0] opcode_r;
reg int_r;
reg [15:0] a_r;
reg [15:0] x_r;
reg [15:0] y_r;
reg [15:0] sp_r;
reg [15:0] dir_r;
reg [15:0] pc_r;
reg [7:0] data_bank_reg;
reg [7:0] program_bank_reg;
reg [7:0] p_r;
reg e_r;
reg [15:0] tmp_r;
reg [15:0] ea_r;
reg [7:0] ctrl_r;

reg [2:0] kind;
reg cyc_last;
reg [15:0] c_addr;
reg [7:0] c_bank;
reg [7:0] c_wdata;
reg rd_hi;
reg ea_load;
reg [15:0] alu_a;
reg [15:0] alu_b;
reg [1:0] alu_op;
reg alu_ci;
reg alu_wide;
reg [7:0] rd_mux;
reg [7:0] p_nxt;
wire [15:0] alu_y;
wire alu_c;
wire alu_v;
wire alu_n;
wire alu_z;

wire run = ctrl_r[0];
wire cyc_start = (ph_r == `CRD_PH_SETUP) && run;
wire cyc_end = (ph_r == `CRD_PH_DATA);
wire take_irq = !irq_n && !p_r[`CRD_P_I];
wire wide_m = !p_r[`CRD_P_M];
wire wide_x = !p_r[`CRD_P_X];
wire op_adc = (opcode_r == `CRD_OP_ADC_IMM);
wire op_and = (opcode_r == `CRD_OP_AND_IMM);
wire op_ldx = (opcode_r == `CRD_OP_LDX_IMM);
wire op_rep = (opcode_r == `CRD_OP_REP);
wire op_sep = (opcode_r == `CRD_OP_SEP);
wire op_sta = (opcode_r == `CRD_OP_STA_DIR);
wire op_xba = (opcode_r == `CRD_OP_XBA);
wire op_xce = (opcode_r == `CRD_OP_XCE);
wire op_bne = (opcode_r == `CRD_OP_BNE);
wire op_brk = (opcode_r == `CRD_OP_BRK);
wire op_pre = (opcode_r == `CRD_OP_LDA_XIND);
wire cls_imm = (opcode_r == `CRD_OP_LDA_IMM) || op_adc || op_and || op_ldx || op_rep || op_sep;
wire cls_dir = (opcode_r == `CRD_OP_LDA_DIR) || op_sta;
wire cls_abx = (opcode_r == `CRD_OP_LDA_ABX);
wire cls_ind = op_pre || (opcode_r == `CRD_OP_LDA_INDY);
wire op_wide = op_ldx ? wide_x : ((op_rep || op_sep) ? 1'b1 : wide_m);
wire [3:0] data_step = cls_dir ? 4'd3 : (cls_abx ? 4'd4 : 4'd7);
wire in_data = (cls_dir || cls_abx || cls_ind) && (cycle_step_counter >= data_step);
wire data_hi = in_data && (cycle_step_counter != data_step);
wire [15:0] vec_base = int_r ? (e_r ? `CRD_VEC_IRQ_EMU : `CRD_VEC_IRQ_NAT) :
	(e_r ? `CRD_VEC_BRK_EMU : `CRD_VEC_BRK_NAT);
wire [15:0] opnd = rd_hi ? {d_in, tmp_r[7:0]} : {8'h00, d_in};
wire exec = cyc_last && ((cls_imm && !op_rep && !op_sep) || (in_data && !op_sta));
wire [15:0] sp_dec = sp_r - 16'h0001;

assign emulation = e_r;

// Cycle decode from opcode and step
always @* begin
	kind = K_INT;
	cyc_last = 1'b0;
	c_addr = pc_r;
	c_bank = program_bank_reg;
	c_wdata = 8'h00;
	rd_hi = 1'b0;
	ea_load = 1'b0;
	if (cycle_step_counter == 4'd0) begin
		if (!take_irq) kind = K_FET;
	end else if (cls_imm) begin
		kind = ((op_rep || op_sep) && cycle_step_counter == 4'd2) ? K_INT : K_PRG;
		rd_hi = !op_rep && !op_sep && cycle_step_counter == 4'd2;
		cyc_last = (cycle_step_counter == 4'd2) || !op_wide;
	end else if (in_data) begin
		kind = op_sta ? K_DWR : K_DRD;
		c_addr = ea_r;
		c_bank = (cls_dir || (cls_ind && cycle_step_counter < 4'd7)) ? 8'h00 : data_bank_reg;
		c_wdata = data_hi ? a_r[15:8] : a_r[7:0];
		rd_hi = data_hi;
		cyc_last = data_hi || !wide_m;
	end else if (cls_dir || cls_abx || cls_ind) begin
		if (cls_abx) begin
			kind = (cycle_step_counter == 4'd3) ? K_INT : K_PRG;
			rd_hi = cycle_step_counter == 4'd2;
			ea_load = cycle_step_counter == 4'd3;
		end else if (cycle_step_counter == 4'd1) begin
			kind = K_PRG;
		end else if (cls_ind && (cycle_step_counter == 4'd4 || cycle_step_counter == 4'd5)) begin
			kind = K_DRD;
			c_addr = ea_r;
			c_bank = 8'h00;
			rd_hi = cycle_step_counter == 4'd5;
		end else begin
			ea_load = 1'b1;
		end
	end else if (op_bne) begin
		kind = (cycle_step_counter == 4'd1) ? K_PRG : K_INT;
		ea_load = 1'b0;
		cyc_last = (cycle_step_counter == 4'd2) || p_r[`CRD_P_Z];
	end else if (op_brk) begin
		c_addr = sp_r;
		c_bank = 8'h00;
		case (cycle_step_counter)
		4'd1: begin
			kind = int_r ? K_INT : K_PRG;
			c_addr = pc_r;
			c_bank = program_bank_reg;
		end
		4'd2: begin
			kind = e_r ? K_INT : K_PUSH;
			c_wdata = program_bank_reg;
		end
		4'd3: begin
			kind = K_PUSH;
			c_wdata = pc_r[15:8];
		end
		4'd4: begin
			kind = K_PUSH;
			c_wdata = pc_r[7:0];
		end
		4'd5: begin
			kind = K_PUSH;
			c_wdata = e_r ? {p_r[7:5], !int_r, p_r[3:0]} : p_r;
		end
		default: begin
			kind = K_VEC;
			c_addr = (cycle_step_counter == 4'd6) ? vec_base : {vec_base[15:1], 1'b1};
			cyc_last = cycle_step_counter != 4'd6;
		end
		endcase
	end else begin
		cyc_last = 1'b1;
	end
end

// Operand routing into the shared ALU
always @* begin
	alu_a = a_r;
	alu_b = 16'h0000;
	alu_op = `CRD_ALU_ADD;
	alu_ci = 1'b0;
	alu_wide = 1'b1;
	if (exec) begin
		alu_a = op_ldx ? x_r : a_r;
		alu_b = opnd;
		alu_op = op_adc ? `CRD_ALU_ADD : (op_and ? `CRD_ALU_AND : `CRD_ALU_PASS);
		alu_ci = op_adc & p_r[`CRD_P_C];
		alu_wide = op_wide;
	end else if (op_bne) begin
		alu_a = pc_r;
		alu_b = {{8{tmp_r[7]}}, tmp_r[7:0]};
	end else if (cls_abx) begin
		alu_a = tmp_r;
		alu_b = x_r;
	end else if (cycle_step_counter == 4'd2) begin
		alu_a = dir_r;
		alu_b = {8'h00, tmp_r[7:0]};
	end else if (cycle_step_counter == 4'd3) begin
		alu_a = ea_r;
		alu_b = op_pre ? x_r : 16'h0000;
	end else begin
		alu_a = tmp_r;
		alu_b = op_pre ? 16'h0000 : y_r;
	end
end

crd_alu u_alu (
	.a(alu_a),
	.b(alu_b),
	.ci(alu_ci),
	.op(alu_op),
	.wide(alu_wide),
	.y(alu_y),
	.co(alu_c),
	.vo(alu_v),
	.no(alu_n),
	.zo(alu_z)
);

// Mode bits after a status change; emulation pins both widths high
always @* begin
	p_nxt = op_rep ? (p_r & ~tmp_r[7:0]) : (p_r | tmp_r[7:0]);
	if (e_r) begin
		p_nxt[`CRD_P_M] = 1'b1;
		p_nxt[`CRD_P_X] = 1'b1;
	end
end

// Bus pins, three clocks per bus cycle
always @(posedge clk or posedge rst) begin
	if (rst) begin
		ph_r <= `CRD_PH_SETUP;
		addr <= 16'h0000;
		d_out <= 8'h00;
		d_oe_n <= 1'b1;
		rw <= 1'b1;
		data_address_valid <= 1'b0;
		program_address_valid <= 1'b0;
		vector_pull_n <= 1'b1;
	end else if (cyc_start) begin
		ph_r <= `CRD_PH_BANK;
		addr <= c_addr;
		d_out <= c_bank;
		d_oe_n <= (kind == K_INT);
		rw <= !(kind == K_DWR || kind == K_PUSH);
		data_address_valid <= (kind == K_FET) || (kind >= K_DRD);
		program_address_valid <= (kind == K_FET) || (kind == K_PRG);
		vector_pull_n <= !(kind == K_VEC);
	end else if (ph_r == `CRD_PH_BANK) begin
		ph_r <= `CRD_PH_DATA;
		d_out <= c_wdata;
		d_oe_n <= !(kind == K_DWR || kind == K_PUSH);
	end else if (cyc_end) begin
		ph_r <= `CRD_PH_SETUP;
		d_oe_n <= 1'b1;
		rw <= 1'b1;
		data_address_valid <= 1'b0;
		program_address_valid <= 1'b0;
		vector_pull_n <= 1'b1;
	end
end

// Register section, updated at the end of each bus cycle
always @(posedge clk or posedge rst) begin
	if (rst) begin
		cycle_step_counter <= 4'd0;
		opcode_r <= `CRD_OP_NOP;
		int_r <= 1'b0;
		a_r <= 16'h0000;
		x_r <= 16'h0000;
		y_r <= 16'h0000;
		sp_r <= `CRD_RST_SP;
		dir_r <= `CRD_RST_DIR;
		pc_r <= RESET_PC;
		data_bank_reg <= `CRD_RST_BANK;
		program_bank_reg <= `CRD_RST_BANK;
		p_r <= `CRD_RST_P;
		e_r <= 1'b1;
		tmp_r <= 16'h0000;
		ea_r <= 16'h0000;
	end else if (cyc_end) begin
		cycle_step_counter <= cyc_last ? 4'd0 : cycle_step_counter + 4'd1;
		if (cycle_step_counter == 4'd0 && take_irq) begin
			opcode_r <= `CRD_OP_BRK;
			int_r <= 1'b1;
		end
		case (kind)
		K_FET: begin
			opcode_r <= d_in;
			pc_r <= pc_r + 16'h0001;
		end
		K_PRG, K_DRD: begin
			if (rd_hi)
				tmp_r[15:8] <= d_in;
			else
				tmp_r[7:0] <= d_in;
			if (kind == K_PRG)
				pc_r <= pc_r + 16'h0001;
			else
				ea_r <= ea_r + 16'h0001;
		end
		K_DWR: ea_r <= ea_r + 16'h0001;
		K_PUSH: sp_r <= e_r ? {`CRD_SP_PAGE, sp_dec[7:0]} : sp_dec;
		K_VEC: begin
			if (cyc_last) begin
				pc_r <= {d_in, tmp_r[7:0]};
				program_bank_reg <= 8'h00;
				p_r[`CRD_P_I] <= 1'b1;
				p_r[`CRD_P_D] <= 1'b0;
				int_r <= 1'b0;
			end else begin
				tmp_r[7:0] <= d_in;
			end
		end
		default: begin
			if (ea_load)
				ea_r <= alu_y;
			if (op_bne && cycle_step_counter == 4'd2)
				pc_r <= alu_y;
			if ((op_rep || op_sep) && cycle_step_counter == 4'd2) begin
				p_r <= p_nxt;
				if (p_nxt[`CRD_P_X]) begin
					x_r[15:8] <= 8'h00;
					y_r[15:8] <= 8'h00;
				end
			end
			if (op_xba && cycle_step_counter == 4'd1) begin
				a_r <= {a_r[7:0], a_r[15:8]};
				p_r[`CRD_P_N] <= a_r[15];
				p_r[`CRD_P_Z] <= (a_r[15:8] == 8'h00);
			end
			if (op_xce && cycle_step_counter == 4'd1) begin
				e_r <= p_r[`CRD_P_C];
				p_r[`CRD_P_C] <= e_r;
				if (p_r[`CRD_P_C]) begin
					p_r[`CRD_P_M] <= 1'b1;
					p_r[`CRD_P_X] <= 1'b1;
					x_r[15:8] <= 8'h00;
					y_r[15:8] <= 8'h00;
					sp_r[15:8] <= `CRD_SP_PAGE;
				end
			end
		end
		endcase
		if (exec) begin
			if (op_ldx)
				x_r <= alu_y;
			else
				a_r <= alu_y;
			p_r[`CRD_P_N] <= alu_n;
			p_r[`CRD_P_Z] <= alu_z;
			if (op_adc) begin
				p_r[`CRD_P_C] <= alu_c;
				p_r[`CRD_P_V] <= alu_v;
			end
		end
	end
end

// Control register and state readback
always @(posedge clk or posedge rst) begin
	if (rst) begin
		ctrl_r <= `CRD_CTRL_RST;
		reg_rdata <= 8'h00;
	end else begin
		if (reg_we && reg_addr == `CRD_REG_CTRL)
			ctrl_r <= {7'h00, reg_wdata[0]};
		reg_rdata <= reg_re ? rd_mux : 8'h00;
	end
end

always @* begin
	case (reg_addr)
	`CRD_REG_CTRL: rd_mux = ctrl_r;
	`CRD_REG_A_LO: rd_mux = a_r[7:0];
	`CRD_REG_A_HI: rd_mux = a_r[15:8];
	`CRD_REG_X_LO: rd_mux = x_r[7:0];
	`CRD_REG_X_HI: rd_mux = x_r[15:8];
	`CRD_REG_Y_LO: rd_mux = y_r[7:0];
	`CRD_REG_Y_HI: rd_mux = y_r[15:8];
	`CRD_REG_P: rd_mux = p_r;
	`CRD_REG_EMU: rd_mux = {7'h00, e_r};
	`CRD_REG_DBANK: rd_mux = data_bank_reg;
	`CRD_REG_PBANK: rd_mux = program_bank_reg;
	`CRD_REG_PC_LO: rd_mux = pc_r[7:0];
	`CRD_REG_PC_HI: rd_mux = pc_r[15:8];
	`CRD_REG_DIR_LO: rd_mux = dir_r[7:0];
	`CRD_REG_DIR_HI: rd_mux = dir_r[15:8];
	`CRD_REG_STEP: rd_mux = {4'h0, cycle_step_counter};
	`CRD_REG_SP_LO: rd_mux = sp_r[7:0];
	`CRD_REG_SP_HI: rd_mux = sp_r[15:8];
	`CRD_REG_OPCODE: rd_mux = opcode_r;
	default: rd_mux = 8'h00;
	endcase
end

endmodule

// [tb/crd_datapath_asserts.sv]
`timescale 1ns/10ps
module crd_datapath_asserts (
	input wire clk,
	input wire rst,
	input wire [7:0] d_in,
	input wire [7:0] d_out,
	input wire d_oe_n,
	input wire [15:0] addr,
	input wire rw,
	input wire data_address_valid,
	input wire program_address_valid,
	input wire vector_pull_n,
	input wire emulation
);
	reg [7:0] op_seen_r;
	wire any_valid = data_address_valid | program_address_valid;

	// Opcode as it crosses the bus at the end of a fetch
	always @(posedge clk or posedge rst) begin
		if (rst)
			op_seen_r <= 8'h00;
		else if (data_address_valid && program_address_valid && d_oe_n)
			op_seen_r <= d_in;
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_vec_pull;
		$fell(vector_pull_n) && $past(vector_pull_n, 3) |-> !addr[0] ##1 !vector_pull_n
			##1 vector_pull_n ##1 !vector_pull_n && addr[0] ##1 !vector_pull_n
			##1 vector_pull_n [*4];
	endproperty
	a_vec_pull: assert property (p_vec_pull) else $error("vector read pair wrong");

	property p_vec_read;
		!vector_pull_n |-> data_address_valid && !program_address_valid && rw
			&& addr[15:5] == 11'h7FF;
	endproperty
	a_vec_read: assert property (p_vec_read) else $error("vector read cycle wrong");

	property p_bank_half;
		$rose(any_valid) |-> !d_oe_n && d_out == 8'h00;
	endproperty
	a_bank_half: assert property (p_bank_half) else $error("bank byte missing");

	property p_write_data;
		!rw |-> data_address_valid && !program_address_valid && vector_pull_n;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write cycle type wrong");

	property p_internal;
		!any_valid |-> d_oe_n && rw && vector_pull_n;
	endproperty
	a_internal: assert property (p_internal) else $error("internal cycle drives bus");

	property p_valid_len;
		$rose(data_address_valid) |=> data_address_valid ##1 !data_address_valid;
	endproperty
	a_valid_len: assert property (p_valid_len) else $error("valid length wrong");

	property p_drive_twice;
		!d_oe_n && !$past(d_oe_n) |-> !rw && !$past(rw);
	endproperty
	a_drive_twice: assert property (p_drive_twice) else $error("data half driven on read");

	property p_emu_swap;
		$changed(emulation) |-> op_seen_r == 8'hFB;
	endproperty
	a_emu_swap: assert property (p_emu_swap) else $error("mode flag changed wrongly");

	c_vec: cover property ($fell(vector_pull_n));
	c_write: cover property ($fell(rw));
	c_mode: cover property ($changed(emulation));
endmodule

bind crd_datapath crd_datapath_asserts u_crd_datapath_asserts (
	.clk(clk), .rst(rst), .d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n), .addr(addr), .rw(rw),
	.data_address_valid(data_address_valid), .program_address_valid(program_address_valid),
	.vector_pull_n(vector_pull_n), .emulation(emulation)
);

// [tb/crd_mem_model.sv]
`timescale 1ns/10ps
module crd_mem_model (
	input wire clk,
	input wire [15:0] addr,
	input wire [7:0] d_out,
	input wire d_oe_n,
	input wire rw,
	input wire data_address_valid,
	input wire program_address_valid,
	output reg [7:0] d_in
);
	reg [7:0] mem [0:65535];
	reg [7:0] last_r = 8'h00;
	wire sel = data_address_valid | program_address_valid;

	// Released bus toggles so a stale byte never reads as valid
	always @* begin
		if (sel && rw && d_oe_n)
			d_in = mem[addr];
		else
			d_in = ~last_r;
	end

	// Bank byte lands first, the data half then overwrites it
	always @(posedge clk) begin
		last_r <= d_in;
		if (sel && !rw && !d_oe_n)
			mem[addr] <= d_out;
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
	localparam [15:0] START = 16'h0200;
	localparam [191:0] PROG1 = 192'h00FB_C234_A934_1269_0100_A2FF_80E2_1085_10E2_20EB_A900_D002;
	localparam [191:0] PROG2 = 192'hC234_A205_BDFE_0129_0385_20A9_0285_21A1_1B85_22A5_20D0_01EB;
	reg clk;
	reg rst;
	reg irq_n;
	reg [4:0] reg_addr;
	reg [7:0] reg_wdata;
	reg reg_we;
	reg reg_re;
	wire [7:0] d_in;
	wire [7:0] d_out;
	wire [7:0] reg_rdata;
	wire [15:0] addr;
	wire d_oe_n;
	wire rw;
	wire dav;
	wire pav;
	wire vpull_n;
	wire emulation;
	integer fail_count;
	integer n_compared;
	integer cycles;

	crd_datapath #(.RESET_PC(START)) u_crd_datapath (
		.clk(clk), .rst(rst), .d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n), .addr(addr),
		.rw(rw), .data_address_valid(dav), .program_address_valid(pav),
		.vector_pull_n(vpull_n), .emulation(emulation), .irq_n(irq_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata)
	);
	crd_mem_model u_crd_mem_model (
		.clk(clk), .addr(addr), .d_out(d_out), .d_oe_n(d_oe_n), .rw(rw),
		.data_address_valid(dav), .program_address_valid(pav), .d_in(d_in)
	);

	always #5 clk = ~clk;

	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles >= 8000) begin
			fail_count = fail_count + 1;
			$display("[ERR] timeout expected done seen running");
			summarize;
		end
	end

	task check(input string what, input [7:0] exp, input [7:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task rd_chk(input [4:0] a, input [7:0] exp, input string what);
		begin
			reg_addr <= a;
			reg_re <= 1'b1;
			@(posedge clk);
			reg_re <= 1'b0;
			@(posedge clk);
			check(what, exp, reg_rdata);
		end
	endtask

	task reg_wr(input [4:0] a, input [7:0] v);
		begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_we <= 1'b1;
			@(posedge clk);
			reg_we <= 1'b0;
			@(posedge clk);
		end
	endtask

	// Unused memory reads as single-byte no-ops
	task load(input [191:0] p, input integer n);
		integer k;
		begin
			for (k = 0; k < 65536; k = k + 1)
				u_crd_mem_model.mem[k] = 8'hEA;
			for (k = 0; k < n; k = k + 1)
				u_crd_mem_model.mem[START + k] = p[8 * (n - 1 - k) +: 8];
		end
	endtask

	task wait_fetch(input [15:0] a);
		integer k;
		begin
			k = 0;
			while (!(dav && pav && addr === a) && k < 1000) begin
				@(posedge clk);
				k = k + 1;
			end
			check("fetch", a[7:0], (k < 1000) ? addr[7:0] : ~a[7:0]);
		end
	endtask

	task take_irq(input [15:0] vec);
		integer k;
		begin
			irq_n <= 1'b0;
			k = 0;
			while (vpull_n !== 1'b0 && k < 300) begin
				@(posedge clk);
				k = k + 1;
			end
			irq_n <= 1'b1;
			check("vector lo", vec[7:0], addr[7:0]);
			check("vector hi", vec[15:8], addr[15:8]);
			wait_fetch(16'hEAEA);
		end
	endtask

	task reset_run;
		begin
			rst <= 1'b1;
			repeat (20) @(posedge clk);
			rst <= 1'b0;
			rd_chk(5'h08, 8'h01, "emulation");
			rd_chk(5'h09, 8'h00, "data bank");
			rd_chk(5'h0D, 8'h00, "direct lo");
			rd_chk(5'h0E, 8'h00, "direct hi");
			rd_chk(5'h0A, 8'h00, "program bank");
		end
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b0;
		irq_n = 1'b1;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		load(PROG1, 23);
		reset_run;
		reg_wr(5'h09, 8'hFF);
		rd_chk(5'h09, 8'h00, "bank write");
		rd_chk(5'h1F, 8'h00, "unmapped");
		reg_wr(5'h00, 8'h00);
		repeat (4) @(posedge clk);
		check("halted", 8'h00, {6'h00, dav, pav});
		rd_chk(5'h00, 8'h00, "run off");
		reg_wr(5'h00, 8'h01);
		wait_fetch(16'h0217);
		rd_chk(5'h01, 8'h00, "acc lo");
		rd_chk(5'h02, 8'h36, "acc hi");
		rd_chk(5'h03, 8'hFF, "x lo");
		rd_chk(5'h04, 8'h00, "x hi");
		rd_chk(5'h07, 8'h32, "status");
		rd_chk(5'h08, 8'h00, "native");
		rd_chk(5'h12, 8'hEA, "opcode");
		check("store lo", 8'h36, u_crd_mem_model.mem[16'h0010]);
		check("store hi", 8'h12, u_crd_mem_model.mem[16'h0011]);
		take_irq(16'hFFEE);
		check("push bank", 8'h00, u_crd_mem_model.mem[16'h01FF]);
		check("push status", 8'h32, u_crd_mem_model.mem[16'h01FC]);
		rd_chk(5'h07, 8'h36, "status irq");
		load(PROG2, 24);
		reset_run;
		wait_fetch(START + 16'h0020);
		rd_chk(5'h07, 8'h30, "emu status");
		rd_chk(5'h01, 8'h01, "branch taken");
		rd_chk(5'h03, 8'h05, "x narrow");
		check("indexed", 8'h01, u_crd_mem_model.mem[16'h0020]);
		check("direct", 8'h02, u_crd_mem_model.mem[16'h0021]);
		check("pre-indexed", 8'h34, u_crd_mem_model.mem[16'h0022]);
		take_irq(16'hFFFE);
		check("emu push status", 8'h20, u_crd_mem_model.mem[16'h01FD]);
		check("no bank push", 8'hEA, u_crd_mem_model.mem[16'h01FC]);
		rd_chk(5'h11, 8'h01, "stack hi");
		summarize;
	end
endmodule
